// [pkg/sync_ctrl_map.svh]
// offsets, field positions, reset values and divider ratios for the sync control
`ifndef SYNC_CTRL_MAP_SVH
`define SYNC_CTRL_MAP_SVH

// ********************************************************************
// register map
// ********************************************************************
`define DIV_ALIGN_CTRL_ADDR 13'h0100
`define DIV_ALIGN_CTRL_RESET 8'h00
`define OUTPUT_MODE_ADDR 13'h0014
`define OUTPUT_MODE_RESET 8'h00

// ********************************************************************
// field positions
// ********************************************************************
`define GLOBAL_EN_BIT 0
`define DIV_GATE_BIT 1
`define ONE_SHOT_BIT 2
`define LIVE_BITS_MASK 8'h07
`define OUTPUT_TYPE_BIT 6

// ********************************************************************
// divider
// ********************************************************************
`define DIV_RATIO_DEFAULT 4'h1
`define DIV_RATIO_MAX 4'h8

`endif

// [pkg/sync_ctrl_pkg.sv]
// types shared by the sync control modules
package sync_ctrl_pkg;
    // serial port word: address and data
    typedef logic [12:0] regAddr_t;
    typedef logic [7:0] regData_t;
    // divider phase counter
    typedef logic [3:0] divCount_t;
endpackage : sync_ctrl_pkg

// [pkg/sync_pulse_if.sv]
// carrier between the pin synchroniser and the control core
`timescale 1ns/1ns
interface sync_pulse_if;
    logic pulse; // one-cycle rising edge of the cleaned sync input
    logic level; // settled level of the sync input
    modport src (output pulse, output level);
    modport dst (input pulse, input level);
endinterface : sync_pulse_if

// [rtl/sync_pin_filter.sv]
// three-stage synchroniser and edge detector for the sync pin
`timescale 1ns/1ns
module sync_pin_filter (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic syncPin,
    sync_pulse_if.src out
);
    import sync_ctrl_pkg::*;

    // ****************************************************************
    // synchroniser state
    // ****************************************************************
    logic [2:0] stage_reg; // [0] metastable, [1] and [2] compared
    logic [2:0] stage_next;
    logic level_reg; // accepted level
    logic level_next;
    logic pulse_reg; // rising-edge pulse
    logic pulse_next;

    // next values: a change counts only once stages 1 and 2 agree
    always_comb begin
        stage_next = {stage_reg[1:0], syncPin};
        level_next = level_reg;
        pulse_next = 1'b0;
        if (stage_reg[1] == stage_reg[2]) begin
            level_next = stage_reg[2];
            pulse_next = stage_reg[2] & ~level_reg;
        end
    end

    // registers only; stage 0 read only by stage 1
    always_ff @(posedge core_clk) begin
        if (srst) begin
            stage_reg <= 3'h0;
            level_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end else begin
            stage_reg <= stage_next;
            level_reg <= level_next;
            pulse_reg <= pulse_next;
        end
    end

    assign out.pulse = pulse_reg;
    assign out.level = level_reg;
endmodule : sync_pin_filter

// [rtl/clock_divider_sync_control.sv]
// divider alignment control with its register and output type strap
// Notes on behaviour
// - bits 7:3 ignore writes, read zero
// - nothing aligns unless global enable set
// - gate plus global enable: every pulse aligns
// - one-shot mode aligns only first pulse
// - one-shot alignment clears gate bit itself
// - strap picks LVDS or CMOS, software LVDS
`timescale 1ns/1ns
`include "sync_ctrl_map.svh"
module clock_divider_sync_control (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic syncPin,
    input wire logic lvdsStrap,
    input wire logic regWrite,
    input wire logic regRead,
    input wire sync_ctrl_pkg::regAddr_t regAddr,
    input wire sync_ctrl_pkg::regData_t regWdata,
    output sync_ctrl_pkg::regData_t regRdata,
    input wire sync_ctrl_pkg::divCount_t divRatio,
    output logic divAlign,
    output logic lvdsMode,
    output sync_ctrl_pkg::divCount_t divPhase
);
    import sync_ctrl_pkg::*;

    // ****************************************************************
    // sync input conditioning
    // ****************************************************************
    sync_pulse_if syncBus ();

    sync_pin_filter pinFilter (
        .core_clk(core_clk),
        .srst(srst),
        .syncPin(syncPin),
        .out(syncBus)
    );

    // ****************************************************************
    // control register and alignment
    // ****************************************************************
    logic [2:0] ctrl_reg; // live bits of the control register
    logic [2:0] ctrl_next;
    logic align_reg; // one-cycle divider reset request
    logic align_next;
    logic outType_reg; // 1 = lvds
    logic outType_next;
    logic strapDone_reg; // strap captured since reset release
    logic strapDone_next;
    logic [2:0] strapSync_reg; // strap pin synchroniser
    logic [2:0] strapSync_next;
    regData_t rdata_reg;
    regData_t rdata_next;
    divCount_t phase_reg;
    divCount_t phase_next;
    logic accept; // a sync pulse passes the gates
    logic strapSettled; // last strap stage, watched by the checks

    // address match shared by read and write decode
    function automatic logic hit(input regAddr_t a, input regAddr_t t);
        hit = (a == t);
    endfunction : hit

    // gating: both enables needed, gate bit passes pulses
    assign accept = syncBus.pulse & ctrl_reg[`GLOBAL_EN_BIT]
        & ctrl_reg[`DIV_GATE_BIT];

    // next values of control, strap and read data
    always_comb begin
        ctrl_next = ctrl_reg;
        align_next = accept;
        outType_next = outType_reg;
        strapDone_next = 1'b1;
        strapSync_next = {strapSync_reg[1:0], lvdsStrap};
        rdata_next = rdata_reg;
        // only the live low bits take a write; upper bits are dropped
        if (regWrite && hit(regAddr, `DIV_ALIGN_CTRL_ADDR)) begin
            ctrl_next = regWdata[2:0];
        end
        // hardware clear wins over a same-cycle write of the gate
        if (accept && ctrl_reg[`ONE_SHOT_BIT]) begin
            ctrl_next[`DIV_GATE_BIT] = 1'b0;
        end
        // strap taken once after reset; settled stages must agree
        if (!strapDone_reg && strapSync_reg[1] == strapSync_reg[2]) begin
            outType_next = strapSync_reg[2];
        end else if (!strapDone_reg) begin
            strapDone_next = 1'b0;
        end
        // software may select lvds later
        if (regWrite && hit(regAddr, `OUTPUT_MODE_ADDR)
            && regWdata[`OUTPUT_TYPE_BIT]) begin
            outType_next = 1'b1;
        end
        // read: reserved bits read zero, unmapped reads zero
        if (regRead) begin
            if (hit(regAddr, `DIV_ALIGN_CTRL_ADDR)) begin
                rdata_next = {5'h00, ctrl_reg};
            end else if (hit(regAddr, `OUTPUT_MODE_ADDR)) begin
                rdata_next = {1'b0, outType_reg, 6'h00};
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    // divider phase counter, returned to zero on alignment
    always_comb begin
        phase_next = phase_reg + 4'h1;
        if (align_reg || phase_reg + 4'h1 >= divRatio) begin
            phase_next = 4'h0;
        end
    end

    // registers only; the strap stages keep sampling through reset, so
    // the pin level is already settled when reset lets go
    always_ff @(posedge core_clk) begin
        strapSync_reg <= strapSync_next;
        if (srst) begin
            ctrl_reg <= 3'h0;
            align_reg <= 1'b0;
            outType_reg <= 1'b0;
            strapDone_reg <= 1'b0;
            rdata_reg <= 8'h00;
            phase_reg <= 4'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            align_reg <= align_next;
            outType_reg <= outType_next;
            strapDone_reg <= strapDone_next;
            rdata_reg <= rdata_next;
            phase_reg <= phase_next;
        end
    end

    assign regRdata = rdata_reg;
    assign divAlign = align_reg;
    assign lvdsMode = outType_reg;
    assign divPhase = phase_reg;
    assign strapSettled = strapSync_reg[2];

    // ****************************************************************
    // checks
    // ****************************************************************
    // a pulse arriving with all three control bits set
    sequence oneShotHit;
        syncBus.pulse && ctrl_reg == 3'h7;
    endsequence

    // a write strobe aimed at the control register
    sequence ctrlWrite;
        regWrite && regAddr == `DIV_ALIGN_CTRL_ADDR;
    endsequence

    // a read strobe aimed at the control register
    sequence ctrlRead;
        regRead && regAddr == `DIV_ALIGN_CTRL_ADDR;
    endsequence

    // the divider only moves when both enables were set a cycle before
    enable_gate_a: assert property (
        @(posedge core_clk) disable iff (srst)
        divAlign |-> ($past(ctrl_reg) & 3'h3) == 3'h3)
        else $error("alignment without both enables");

    // with the global enable low no pulse may reach the divider
    enable_idle_a: assert property (
        @(posedge core_clk) disable iff (srst)
        !ctrl_reg[`GLOBAL_EN_BIT] |=> !divAlign)
        else $error("alignment with global enable low");

    // continuous mode: every accepted pulse realigns
    cont_mode_a: assert property (
        @(posedge core_clk) disable iff (srst)
        syncBus.pulse && ctrl_reg[1:0] == 2'h3 |=> divAlign)
        else $error("pulse lost in continuous mode");

    // continuous mode leaves the gate open for the next pulse
    gate_hold_a: assert property (
        @(posedge core_clk) disable iff (srst)
        syncBus.pulse && ctrl_reg == 3'h3 && !regWrite |=> ctrl_reg == 3'h3)
        else $error("continuous mode closed the gate");

    // one-shot: the first pulse shuts the gate behind it
    one_shot_a: assert property (
        @(posedge core_clk) disable iff (srst)
        oneShotHit |=> !ctrl_reg[`DIV_GATE_BIT])
        else $error("one-shot did not close the gate");

    // a closed gate reads back as zero
    gate_clear_a: assert property (
        @(posedge core_clk) disable iff (srst)
        ctrlRead ##0 !ctrl_reg[`DIV_GATE_BIT] |=> !regRdata[`DIV_GATE_BIT])
        else $error("gate bit reads back set");

    // reserved bits never show on a read
    upper_zero_a: assert property (
        @(posedge core_clk) disable iff (srst)
        $past(regRead) && $past(regAddr) == `DIV_ALIGN_CTRL_ADDR
        |-> regRdata[7:3] == 5'h00)
        else $error("reserved bits read nonzero");

    // a write keeps only the live bits; a same-cycle pulse is left out
    // because the one-shot clear may override the gate bit then
    upper_drop_a: assert property (
        @(posedge core_clk) disable iff (srst)
        ctrlWrite ##0 !syncBus.pulse |=> {5'h00, ctrl_reg}
            == ($past(regWdata) & `LIVE_BITS_MASK))
        else $error("control write not taken as live bits");

    // the counter restarts right after an alignment
    phase_reset_a: assert property (
        @(posedge core_clk) disable iff (srst)
        divAlign |=> divPhase == 4'h0)
        else $error("divider not realigned");

    // first settled strap level after reset sets the output type
    strap_take_a: assert property (
        @(posedge core_clk) disable iff (srst)
        !strapDone_reg && strapSync_reg[1] == strapSync_reg[2]
        && !regWrite |=> lvdsMode == $past(strapSettled))
        else $error("strap not captured");

    // once captured, only a software write may move the output type
    strap_once_a: assert property (
        @(posedge core_clk) disable iff (srst)
        strapDone_reg && !regWrite |=> $stable(lvdsMode))
        else $error("output type moved without a write");

    // software can select lvds but never fall back to cmos
    lvds_sticky_a: assert property (
        @(posedge core_clk) disable iff (srst)
        strapDone_reg && lvdsMode |=> lvdsMode)
        else $error("lvds mode dropped");
endmodule : clock_divider_sync_control

// [sim/sync_source_model.sv]
// sync pulse source standing in for the system timing logic
`timescale 1ns/1ns
module sync_source_model (
    input wire logic core_clk,
    input wire logic fire,
    output logic syncPin
);
    // ********************************************************************
    // pulse shaping
    // ********************************************************************
    logic [2:0] holdCnt; // cycles left with the pin high
    initial begin
        holdCnt = 3'h0;
        syncPin = 1'b0;
    end
    // four cycles high, then low: each level well past the two-cycle minimum
    always @(posedge core_clk) begin
        if (fire) begin
            holdCnt <= 3'h4;
        end else if (holdCnt != 3'h0) begin
            holdCnt <= holdCnt - 3'h1;
        end
        syncPin <= fire || (holdCnt > 3'h1);
    end
endmodule : sync_source_model

// [sim/clock_divider_sync_control_tb.sv]
// self-checking bench for the divider alignment control
`timescale 1ns/1ns
module clock_divider_sync_control_tb;
    import sync_ctrl_pkg::*;
    // ********************************************************************
    // stimulus signals
    // ********************************************************************
    logic core_clk = 1'b0;
    logic srst = 1'b1; // held through the first ten cycles
    logic fire = 1'b0; // asks the source model for one pulse
    logic syncPin;
    logic lvdsStrap = 1'b0; // low first: output comes up as CMOS
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    regAddr_t regAddr = 13'h0000;
    regData_t regWdata = 8'h00;
    regData_t regRdata;
    divCount_t divRatio = 4'h4; // fixed ratio, the divider itself is not ours
    logic divAlign;
    logic lvdsMode;
    divCount_t divPhase;
    logic [7:0] nAlign = 8'h00; // alignments seen so far
    logic alignSeen = 1'b0; // divAlign was high at the last edge
    int errors = 0;
    int n_checks = 0;
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    sync_source_model partner (.core_clk(core_clk), .fire(fire),
        .syncPin(syncPin));
    clock_divider_sync_control uut (.core_clk(core_clk), .srst(srst),
        .syncPin(syncPin), .lvdsStrap(lvdsStrap), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .divRatio(divRatio), .divAlign(divAlign),
        .lvdsMode(lvdsMode), .divPhase(divPhase));
    // ********************************************************************
    // tasks
    // ********************************************************************
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h wanted %h", $time,
                seen, exp);
        end
    endtask : check
    task end_of_test;
        if (errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task reg_write(input regAddr_t a, input regData_t d);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : reg_write
    // read data lands one cycle after the strobe edge, sampled mid-cycle
    task reg_expect(input regAddr_t a, input regData_t exp);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRead <= 1'b0;
        @(negedge core_clk);
        check(regRdata, exp);
    endtask : reg_expect
    // one pulse, then a window long enough for synchroniser and alignment
    task fire_sync;
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        repeat (14) @(posedge core_clk);
    endtask : fire_sync
    // counts alignments; phase must restart the cycle after each one
    always @(posedge core_clk) begin
        if (alignSeen) begin
            check({4'h0, divPhase}, 8'h00);
        end
        alignSeen <= divAlign;
        if (divAlign === 1'b1) begin
            nAlign <= nAlign + 8'h01;
        end
    end
    // ********************************************************************
    // main sequence
    // ********************************************************************
    initial begin
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        repeat (8) @(posedge core_clk);
        reg_expect(13'h0100, 8'h00);
        check({7'h00, lvdsMode}, 8'h00);
        reg_expect(13'h0014, 8'h00);
        reg_write(13'h0100, 8'hFF);
        reg_expect(13'h0100, 8'h07);
        reg_expect(13'h0055, 8'h00);
        // gate alone, then global enable alone: neither may align
        reg_write(13'h0100, 8'h02);
        fire_sync();
        reg_write(13'h0100, 8'h01);
        fire_sync();
        check(nAlign, 8'h00);
        // continuous mode: every pulse aligns, gate stays set
        reg_write(13'h0100, 8'h03);
        fire_sync();
        fire_sync();
        check(nAlign, 8'h02);
        reg_expect(13'h0100, 8'h03);
        // one-shot: only the first pulse counts and the gate drops
        reg_write(13'h0100, 8'h07);
        fire_sync();
        fire_sync();
        check(nAlign, 8'h03);
        reg_expect(13'h0100, 8'h05);
        reg_write(13'h0100, 8'h00);
        // software switch to LVDS, then strap high across a second reset
        reg_write(13'h0014, 8'h40);
        repeat (2) @(posedge core_clk);
        check({7'h00, lvdsMode}, 8'h01);
        reg_expect(13'h0014, 8'h40);
        @(posedge core_clk);
        lvdsStrap <= 1'b1;
        srst <= 1'b1;
        repeat (10) @(posedge core_clk);
        // reset must have dropped the software choice
        check({7'h00, lvdsMode}, 8'h00);
        srst <= 1'b0;
        repeat (10) @(posedge core_clk);
        check({7'h00, lvdsMode}, 8'h01);
        reg_expect(13'h0014, 8'h40);
        reg_expect(13'h0100, 8'h00);
        end_of_test();
    end
    // guard against a hang anywhere in the sequence
    initial begin
        #100000;
        errors++;
        end_of_test();
    end
endmodule : clock_divider_sync_control_tb
